//--- include/mvx_pkg.sv
`default_nettype none
package mvx_pkg;

  // Widths of the instruction word, data path and file address
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;

  // Field positions inside the instruction word
  localparam int DEST_BIT = 7;
  localparam int LIT_LSB  = 0;
  localparam int FADR_LSB = 0;

  // Encodings as mask and pattern; masked-out bits are don't-care
  localparam logic [INSTR_W-1:0] WTOF_MASK = 14'h3F80;
  localparam logic [INSTR_W-1:0] WTOF_PAT  = 14'h0080;
  localparam logic [INSTR_W-1:0] ORWF_MASK = 14'h3F00;
  localparam logic [INSTR_W-1:0] ORWF_PAT  = 14'h0400;
  localparam logic [INSTR_W-1:0] ORLW_MASK = 14'h3F00;
  localparam logic [INSTR_W-1:0] ORLW_PAT  = 14'h3800;
  localparam logic [INSTR_W-1:0] LDLW_MASK = 14'h3C00;
  localparam logic [INSTR_W-1:0] LDLW_PAT  = 14'h3000;
  localparam logic [INSTR_W-1:0] NOPI_MASK = 14'h3F9F;
  localparam logic [INSTR_W-1:0] NOPI_PAT  = 14'h0000;

  // Reset values
  localparam logic [DATA_W-1:0]  W_RST     = 8'h00;
  localparam logic               Z_RST     = 1'b0;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;

  typedef enum logic [2:0] {
    OP_MOVE_WORKING_TO_FILE,
    OP_OR_LITERAL_INTO_WORKING,
    OP_OR_WORKING_WITH_FILE,
    OP_LOAD_LITERAL_TO_WORKING,
    OP_NO_OPERATION_INSTR,
    OP_OUTSIDE_GROUP
  } mvx_op_t;

  function automatic mvx_op_t mvx_decode(input logic [INSTR_W-1:0] iw);
    mvx_op_t op;
    op = OP_OUTSIDE_GROUP;
    if ((iw & WTOF_MASK) == WTOF_PAT)
      op = OP_MOVE_WORKING_TO_FILE;
    else if ((iw & ORWF_MASK) == ORWF_PAT)
      op = OP_OR_WORKING_WITH_FILE;
    else if ((iw & ORLW_MASK) == ORLW_PAT)
      op = OP_OR_LITERAL_INTO_WORKING;
    else if ((iw & LDLW_MASK) == LDLW_PAT)
      op = OP_LOAD_LITERAL_TO_WORKING;
    else if ((iw & NOPI_MASK) == NOPI_PAT)
      op = OP_NO_OPERATION_INSTR;
    return op;
  endfunction

endpackage
`default_nettype wire

//--- rtl/mvx_exec.sv
// Summary of operation
// RULE1: Move-working-to-file writes the working register into the addressed file register in one cycle, flags untouched.
// RULE2: Or-literal ORs the working register with the 8-bit literal, stores it in the working register and sets zero from it.
// RULE3: Or-with-file ORs the working register with the addressed file register and sets zero from the result.
// RULE4: The destination bit of or-with-file sends the result to the working register at 0 and to the file register at 1.
// RULE5: Load-literal (upper bits 11 00xx) puts the 8-bit literal into the working register in one cycle, flags untouched.
// RULE6: Load-literal is recognised whatever its two don't-care bits hold.
// RULE7: The no-operation word, any value in its two don't-care bits, changes no register and no flag in its one cycle.
`timescale 1ns/1ps
`default_nettype none
module mvx_exec (
  // Clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  // Instruction in
  input  wire logic [mvx_pkg::INSTR_W-1:0]  instr,
  input  wire logic                         instr_valid,
  // File register read port
  output logic      [mvx_pkg::FADDR_W-1:0]  file_raddr,
  input  wire logic [mvx_pkg::DATA_W-1:0]   file_rdata,
  // File register write port
  output logic                              file_we_ff,
  output logic      [mvx_pkg::FADDR_W-1:0]  file_waddr_ff,
  output logic      [mvx_pkg::DATA_W-1:0]   file_wdata_ff,
  // Core state
  output logic      [mvx_pkg::DATA_W-1:0]   w_ff,
  output logic                              z_ff,
  output logic                              retire_ff,
  output logic                              outside_ff
);

  mvx_pkg::mvx_op_t                 cur_op;
  logic [mvx_pkg::FADDR_W-1:0]      op_faddr;
  logic [mvx_pkg::DATA_W-1:0]       op_lit;
  logic                             op_dest;
  logic [mvx_pkg::DATA_W-1:0]       fwd_rdata;
  logic [mvx_pkg::DATA_W-1:0]       or_file;
  logic [mvx_pkg::DATA_W-1:0]       or_lit;
  logic [mvx_pkg::DATA_W-1:0]       nxt_w;
  logic                             nxt_z;
  logic                             nxt_file_we;
  logic [mvx_pkg::FADDR_W-1:0]      nxt_file_waddr;
  logic [mvx_pkg::DATA_W-1:0]       nxt_file_wdata;
  logic                             nxt_retire;
  logic                             nxt_outside;

  // RULE6: match on masked bits
  assign cur_op   = mvx_pkg::mvx_decode(instr);
  assign op_faddr = instr[mvx_pkg::FADR_LSB +: mvx_pkg::FADDR_W];
  assign op_lit   = instr[mvx_pkg::LIT_LSB +: mvx_pkg::DATA_W];
  assign op_dest  = instr[mvx_pkg::DEST_BIT];

  assign file_raddr = op_faddr;

  // The file write lands one edge late, so a read of the same address
  // in the next cycle takes the pending value instead of stale storage
  assign fwd_rdata = (file_we_ff && (file_waddr_ff == op_faddr))
                     ? file_wdata_ff : file_rdata;

  assign or_file = w_ff | fwd_rdata;
  assign or_lit  = w_ff | op_lit;

  always_comb
  begin
    nxt_w          = w_ff;
    nxt_z          = z_ff;
    nxt_file_we    = 1'b0;
    nxt_file_waddr = file_waddr_ff;
    nxt_file_wdata = file_wdata_ff;
    nxt_retire     = 1'b0;
    nxt_outside    = 1'b0;
    if (instr_valid)
    begin
      nxt_retire = 1'b1;
      case (cur_op)
        // RULE1: working to file
        mvx_pkg::OP_MOVE_WORKING_TO_FILE:
        begin
          nxt_file_we    = 1'b1;
          nxt_file_waddr = op_faddr;
          nxt_file_wdata = w_ff;
        end
        // RULE2: or literal, zero flag
        mvx_pkg::OP_OR_LITERAL_INTO_WORKING:
        begin
          nxt_w = or_lit;
          nxt_z = (or_lit == '0);
        end
        // RULE3: or with file, zero flag
        mvx_pkg::OP_OR_WORKING_WITH_FILE:
        begin
          nxt_z = (or_file == '0);
          // RULE4: destination select
          if (op_dest)
          begin
            nxt_file_we    = 1'b1;
            nxt_file_waddr = op_faddr;
            nxt_file_wdata = or_file;
          end
          else
          begin
            nxt_w = or_file;
          end
        end
        // RULE5: literal load
        mvx_pkg::OP_LOAD_LITERAL_TO_WORKING:
        begin
          nxt_w = op_lit;
        end
        // RULE7: nothing changes
        mvx_pkg::OP_NO_OPERATION_INSTR:
        begin
          nxt_w = w_ff;
        end
        default:
        begin
          // Other instructions belong to other units; only flag them
          nxt_retire  = 1'b0;
          nxt_outside = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_ff          <= mvx_pkg::W_RST;
      z_ff          <= mvx_pkg::Z_RST;
      file_we_ff    <= 1'b0;
      file_waddr_ff <= mvx_pkg::FADDR_RST;
      file_wdata_ff <= mvx_pkg::W_RST;
      retire_ff     <= 1'b0;
      outside_ff    <= 1'b0;
    end
    else
    begin
      w_ff          <= nxt_w;
      z_ff          <= nxt_z;
      file_we_ff    <= nxt_file_we;
      file_waddr_ff <= nxt_file_waddr;
      file_wdata_ff <= nxt_file_wdata;
      retire_ff     <= nxt_retire;
      outside_ff    <= nxt_outside;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // RULE1: write one edge later
  a_wtof_write_data: assert property ( // RULE1
    instr_valid && cur_op == mvx_pkg::OP_MOVE_WORKING_TO_FILE
    |=> file_we_ff && file_wdata_ff == $past(w_ff)
        && file_waddr_ff == $past(op_faddr)
        && $stable(w_ff) && $stable(z_ff) && retire_ff)
    else $error("working-to-file write wrong");

  // RULE2: literal or and zero
  a_orlit_result_zero: assert property ( // RULE2
    instr_valid && cur_op == mvx_pkg::OP_OR_LITERAL_INTO_WORKING
    |=> w_ff == ($past(w_ff) | $past(op_lit))
        && z_ff == (w_ff == '0) && !file_we_ff)
    else $error("or-literal result or zero wrong");

  // RULE3: file or zero flag
  a_orfile_zero_flag: assert property ( // RULE3
    instr_valid && cur_op == mvx_pkg::OP_OR_WORKING_WITH_FILE
    |=> z_ff == (($past(w_ff) | $past(fwd_rdata)) == '0))
    else $error("or-with-file zero flag wrong");

  // RULE4: result to working register
  a_orfile_dest_w: assert property ( // RULE4
    instr_valid && cur_op == mvx_pkg::OP_OR_WORKING_WITH_FILE && !op_dest
    |=> !file_we_ff && w_ff == ($past(w_ff) | $past(fwd_rdata)))
    else $error("or-with-file to working wrong");

  // RULE4: result to file register
  a_orfile_dest_f: assert property ( // RULE4
    instr_valid && cur_op == mvx_pkg::OP_OR_WORKING_WITH_FILE && op_dest
    |=> file_we_ff && $stable(w_ff)
        && file_waddr_ff == $past(op_faddr)
        && file_wdata_ff == ($past(w_ff) | $past(fwd_rdata)))
    else $error("or-with-file to file wrong");

  // RULE5: literal load keeps flag
  a_ldlit_load_w: assert property ( // RULE5
    instr_valid && cur_op == mvx_pkg::OP_LOAD_LITERAL_TO_WORKING
    |=> w_ff == $past(op_lit) && $stable(z_ff) && !file_we_ff)
    else $error("load-literal wrong");

  // RULE6: don't-care bits ignored
  a_ldlit_dont_care: assert property ( // RULE6
    instr[13:10] == 4'hC |-> cur_op == mvx_pkg::OP_LOAD_LITERAL_TO_WORKING)
    else $error("load-literal not recognised");

  // RULE7: no-operation is idle
  a_noop_keeps_state: assert property ( // RULE7
    instr_valid && (instr & mvx_pkg::NOPI_MASK) == mvx_pkg::NOPI_PAT
    |=> !file_we_ff && $stable(w_ff) && $stable(z_ff) && retire_ff)
    else $error("no-operation changed state");

  a_idle_no_write: assert property (
    !instr_valid |=> !file_we_ff && $stable(w_ff) && $stable(z_ff)
                     && !retire_ff && !outside_ff)
    else $error("state changed without instruction");

  c_wtof_then_orfile: cover property (
    instr_valid && cur_op == mvx_pkg::OP_MOVE_WORKING_TO_FILE
    ##1 instr_valid && cur_op == mvx_pkg::OP_OR_WORKING_WITH_FILE
        && file_we_ff && file_waddr_ff == op_faddr);
  c_orlit_zero: cover property (
    instr_valid && cur_op == mvx_pkg::OP_OR_LITERAL_INTO_WORKING ##1 z_ff);
  c_ldlit_dc_set: cover property (
    instr_valid && instr[13:10] == 4'hC && instr[9:8] == 2'h3);
  c_outside_group: cover property (outside_ff);

endmodule // mvx_exec
`default_nettype wire

//--- bench/mvx_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module mvx_exec_bench;
  typedef struct packed {
    logic [7:0] w;
    logic       z;
    logic       we;
    logic [6:0] wa;
    logic [7:0] wd;
    logic       ret;
    logic       out;
  } mvx_note_t;
  logic        ref_clk;
  logic        rst_n;
  logic [13:0] instr;
  logic        instr_valid;
  logic [6:0]  file_raddr;
  logic [7:0]  file_rdata;
  logic        file_we_ff;
  logic [6:0]  file_waddr_ff;
  logic [7:0]  file_wdata_ff;
  logic [7:0]  w_ff;
  logic        z_ff;
  logic        retire_ff;
  logic        outside_ff;
  logic [7:0]  mem [128];
  logic [7:0]  exp_mem [128];
  logic [7:0]  exp_w;
  logic        exp_z;
  logic [6:0]  exp_wa;
  logic [7:0]  exp_wd;
  logic [13:0] bases [6] = '{14'h0080, 14'h0400, 14'h3800, 14'h3000,
                             14'h0000, 14'h0000};
  logic [13:0] frees [6] = '{14'h007F, 14'h00FF, 14'h00FF, 14'h03FF,
                             14'h0060, 14'h3FFF};
  mvx_note_t   notes [$];
  int          errors;
  int          compares;
  int          seed = 32'h2eb8a6a5;
  int          r;
  // Memory commits only on the design's write pulse; forwarding is its job
  assign file_rdata = mem[file_raddr];
  mvx_exec DUT (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .instr         (instr),
    .instr_valid   (instr_valid),
    .file_raddr    (file_raddr),
    .file_rdata    (file_rdata),
    .file_we_ff    (file_we_ff),
    .file_waddr_ff (file_waddr_ff),
    .file_wdata_ff (file_wdata_ff),
    .w_ff          (w_ff),
    .z_ff          (z_ff),
    .retire_ff     (retire_ff),
    .outside_ff    (outside_ff)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (file_we_ff === 1'b1)
      mem[file_waddr_ff] <= file_wdata_ff;
  task automatic fail(input string msg);
    errors++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic issue(input logic [13:0] iw);
    mvx_note_t  n;
    logic [7:0] res;
    n = '0;
    res = exp_w | exp_mem[iw[6:0]];
    casez (iw)
      14'b00_0000_1???_????:
      begin
        exp_mem[iw[6:0]] = exp_w;
        {n.we, exp_wa, exp_wd} = {1'b1, iw[6:0], exp_w};
      end
      14'b00_0100_????_????:
      begin
        exp_z = (res == 8'h00);
        if (iw[7])
        begin
          exp_mem[iw[6:0]] = res;
          {n.we, exp_wa, exp_wd} = {1'b1, iw[6:0], res};
        end
        else
          exp_w = res;
      end
      14'b11_1000_????_????:
      begin
        exp_w = exp_w | iw[7:0];
        exp_z = (exp_w == 8'h00);
      end
      14'b11_00??_????_????: exp_w = iw[7:0];
      14'b00_0000_0??0_0000: ;
      default: n.out = 1'b1;
    endcase
    n.ret = ~n.out;
    {n.w, n.z, n.wa, n.wd} = {exp_w, exp_z, exp_wa, exp_wd};
    @(posedge ref_clk);
    instr <= iw;
    instr_valid <= 1'b1;
    notes.push_back(n);
  endtask
  always @(negedge ref_clk)
  begin
    mvx_note_t n;
    if (rst_n && (retire_ff === 1'b1 || outside_ff === 1'b1))
    begin
      if (notes.size() == 0)
        fail("result without instruction");
      else
      begin
        n = notes.pop_front();
        compares++;
        if ({w_ff, z_ff, file_we_ff, file_waddr_ff, file_wdata_ff,
             retire_ff, outside_ff} !== n)
          fail("result differs from model");
      end
    end
    else if (rst_n && file_we_ff !== 1'b0)
      fail("write without instruction");
  end
  initial
  begin
    {rst_n, instr_valid, instr} = '0;
    {exp_w, exp_z, exp_wa, exp_wd} = '0;
    for (int i = 0; i < 128; i++)
      {mem[i], exp_mem[i]} = {2{8'(i * 37)}};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    compares++;
    if ({w_ff, z_ff, file_we_ff, file_waddr_ff, file_wdata_ff, retire_ff,
         outside_ff} !== 27'h0)
      fail("reset state wrong");
    issue(14'h304F);
    issue(14'h00A5);
    issue(14'h0425);
    issue(14'h04A5);
    issue(14'h3300);
    issue(14'h3800);
    issue(14'h3880);
    issue(14'h00FF);
    issue(14'h047F);
    for (int i = 0; i < 4; i++)
      issue(14'(i << 5));
    issue(14'h3400);
    issue(14'h0001);
    repeat (400)
    begin
      r = $random(seed);
      issue(bases[r[18:16] % 6] | (14'(r) & frees[r[18:16] % 6]));
      if (r[31])
      begin
        @(posedge ref_clk);
        instr_valid <= 1'b0;
      end
    end
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    for (int i = 0; i < 20 && notes.size() != 0; i++)
      @(posedge ref_clk);
    if (notes.size() != 0)
      fail("results missing");
    complete_run();
  end
endmodule // mvx_exec_bench
`default_nettype wire
